// *** core/hdds_consts.svh ***
`ifndef HDDS_CONSTS_SVH
`define HDDS_CONSTS_SVH
// How it works
// RULE_01: received payload goes to the data buffer as one single-word write per word of packet.
// RULE_02: a finished receive descriptor gets exactly one word overwritten with status and length.
// RULE_03: each received packet puts one vector into the receive queue of its channel.
// RULE_04: after a descriptor the link is followed and the new address goes to the config block.
// RULE_05: a transmit descriptor is fetched as one read burst of three data phases.
// RULE_06: transmit data is read as (bytes + 3) / 4 single-word reads.
// RULE_07: the transmit current-descriptor update is one single-phase write.
// RULE_08: each transmitted packet writes one vector to the transmit queue in one single-phase write.
// RULE_09: a receive descriptor is fetched as one read burst of three data phases.
// RULE_10: the receive status write-back is one single-phase write.
// RULE_11: the receive current-descriptor update is one single-phase write.
// RULE_12: each receive vector is written to the receive queue in one single-phase write.
// RULE_13: transmit order is descriptor, data, then vector to the transmit queue.
// RULE_14: host software builds the lists and config block; the device reads it only on request.
// RULE_15: any number of target wait states is tolerated; a data phase holds until the target ends it.

// ----------------------------------------------------------------
// bus commands and lengths
// ----------------------------------------------------------------
`define HDDS_CMD_MRD    4'h6
`define HDDS_CMD_MWR    4'h7
`define HDDS_BE_ALL     4'h0
`define HDDS_LEN_DESC   2'h3
`define HDDS_LEN_ONE    2'h1

// ----------------------------------------------------------------
// descriptor and config block layout
// ----------------------------------------------------------------
`define HDDS_DW_CTRL    2'h0
`define HDDS_DW_NEXT    2'h1
`define HDDS_DW_DPTR    2'h2
`define HDDS_LEN_MSB    12
`define HDDS_CFG_TX     32'h0000_0000
`define HDDS_CFG_RX     32'h0000_0004
`define HDDS_VEC_TX     8'h01
`define HDDS_VEC_RX     8'h02
`define HDDS_ZERO32     32'h0000_0000

`endif

// *** core/hdds_pkg.sv ***
`default_nettype none
package hdds_pkg;

	// bus engine states
	typedef enum logic [3:0] {
		E_IDLE = 4'h1,
		E_ADDR = 4'h2,
		E_DATA = 4'h4,
		E_TURN = 4'h8
	} hdds_eng_type;

	// packet sequence states
	typedef enum logic [9:0] {
		S_IDLE  = 10'h001,
		S_TDESC = 10'h002,
		S_TDATA = 10'h004,
		S_TIV   = 10'h008,
		S_TCCB  = 10'h010,
		S_RDESC = 10'h020,
		S_RDATA = 10'h040,
		S_RSTAT = 10'h080,
		S_RIV   = 10'h100,
		S_RCCB  = 10'h200
	} hdds_seq_type;

endpackage : hdds_pkg
`default_nettype wire

// *** core/hdds_pci_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hdds_consts.svh"

module hdds_pci_engine (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// transaction request
	input  wire logic        start_i,
	input  wire logic        wr_i,
	input  wire logic [1:0]  len_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic             dph_o,
	output logic             done_o,
	output logic [31:0]      rdata_o,
	// bus pins
	input  wire logic [31:0] ad_i,
	input  wire logic        trdy_n_i,
	output logic [31:0]      ad_o,
	output logic             ad_oe_n_o,
	output logic [3:0]       cbe_n_o,
	output logic             frame_n_o,
	output logic             irdy_n_o
);

	hdds_pkg::hdds_eng_type st_r, st_nxt;
	logic [1:0]  cnt_r, cnt_nxt;
	logic [31:0] ad_r, ad_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
	logic        oe_r, oe_nxt, fr_r, fr_nxt, ir_r, ir_nxt, wr_r, wr_nxt;
	logic [3:0]  cbe_r, cbe_nxt;
	logic        dph_r, dph_nxt, done_r, done_nxt;

	// ----------------------------------------------------------------
	// transaction next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		ad_nxt   = ad_r;
		wd_nxt   = wd_r;
		rd_nxt   = rd_r;
		oe_nxt   = oe_r;
		fr_nxt   = fr_r;
		ir_nxt   = ir_r;
		wr_nxt   = wr_r;
		cbe_nxt  = cbe_r;
		dph_nxt  = 1'b0;
		done_nxt = 1'b0;
		case (st_r)
			hdds_pkg::E_IDLE: begin
				if (start_i) begin
					st_nxt  = hdds_pkg::E_ADDR;
					fr_nxt  = 1'b0;
					ad_nxt  = addr_i;
					oe_nxt  = 1'b0;
					cbe_nxt = wr_i ? `HDDS_CMD_MWR : `HDDS_CMD_MRD;
					cnt_nxt = len_i;
					wr_nxt  = wr_i;
					wd_nxt  = wdata_i;
				end
			end
			hdds_pkg::E_ADDR: begin
				// reads release the bus here for the turnaround
				st_nxt  = hdds_pkg::E_DATA;
				ir_nxt  = 1'b0;
				cbe_nxt = `HDDS_BE_ALL;
				oe_nxt  = ~wr_r;
				ad_nxt  = wd_r;
				fr_nxt  = (cnt_r == `HDDS_LEN_ONE);
			end
			hdds_pkg::E_DATA: begin
				// stay here for as long as the target waits
				if (!trdy_n_i) begin // RULE_15
					dph_nxt = 1'b1;
					rd_nxt  = ad_i;
					cnt_nxt = cnt_r - 2'h1;
					if (cnt_r == `HDDS_LEN_ONE) begin
						done_nxt = 1'b1;
						ir_nxt   = 1'b1;
						oe_nxt   = 1'b1;
						st_nxt   = hdds_pkg::E_TURN;
					end else if (cnt_r == 2'h2) begin
						fr_nxt = 1'b1; // last phase of the burst
					end
				end
			end
			hdds_pkg::E_TURN: st_nxt = hdds_pkg::E_IDLE;
			default: st_nxt = hdds_pkg::E_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r   <= hdds_pkg::E_IDLE;
			cnt_r  <= 2'h0;
			ad_r   <= `HDDS_ZERO32;
			wd_r   <= `HDDS_ZERO32;
			rd_r   <= `HDDS_ZERO32;
			oe_r   <= 1'b1;
			fr_r   <= 1'b1;
			ir_r   <= 1'b1;
			wr_r   <= 1'b0;
			cbe_r  <= 4'hF;
			dph_r  <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			ad_r   <= ad_nxt;
			wd_r   <= wd_nxt;
			rd_r   <= rd_nxt;
			oe_r   <= oe_nxt;
			fr_r   <= fr_nxt;
			ir_r   <= ir_nxt;
			wr_r   <= wr_nxt;
			cbe_r  <= cbe_nxt;
			dph_r  <= dph_nxt;
			done_r <= done_nxt;
		end
	end

	assign ad_o      = ad_r;
	assign ad_oe_n_o = oe_r;
	assign cbe_n_o   = cbe_r;
	assign frame_n_o = fr_r;
	assign irdy_n_o  = ir_r;
	assign dph_o     = dph_r;
	assign done_o    = done_r;
	assign rdata_o   = rd_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_wait_hold;
		@(posedge clk_i) disable iff (rst_i)
		(st_r == hdds_pkg::E_DATA && trdy_n_i) |=> (!irdy_n_o && st_r == hdds_pkg::E_DATA);
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("data phase dropped in wait"); // RULE_15

endmodule : hdds_pci_engine
`default_nettype wire

// *** core/hdds_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hdds_consts.svh"

module hdds_sequencer (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	// transmit request
	input  wire logic        TX_REQ_I,
	input  wire logic [4:0]  TX_CHAN_I,
	input  wire logic [31:0] TX_DESC_I,
	input  wire logic [31:0] TX_IQ_I,
	// receive request
	input  wire logic        RX_REQ_I,
	input  wire logic [4:0]  RX_CHAN_I,
	input  wire logic [31:0] RX_DESC_I,
	input  wire logic [31:0] RX_IQ_I,
	input  wire logic [12:0] RX_LEN_I,
	input  wire logic [15:0] RX_STAT_I,
	input  wire logic [31:0] RX_DATA_I,
	output logic             RX_TAKE_O,
	// configuration
	input  wire logic [31:0] CFG_BASE_I,
	// transmit data out
	output logic [31:0]      TX_DATA_O,
	output logic             TX_DATA_VLD_O,
	// status
	output logic             BUSY_O,
	output logic             TX_DONE_O,
	output logic             RX_DONE_O,
	output logic [31:0]      NEXT_DESC_O,
	// bus pins
	input  wire logic [31:0] AD_I,
	input  wire logic        TRDY_N_I,
	output logic [31:0]      AD_O,
	output logic             AD_OE_N_O,
	output logic [3:0]       CBE_N_O,
	output logic             FRAME_N_O,
	output logic             IRDY_N_O
);

	hdds_pkg::hdds_seq_type st_r, st_nxt;
	logic        pend_r, pend_nxt;
	logic [11:0] cnt_r, cnt_nxt;
	logic [12:0] len_r, len_nxt;
	logic [15:0] stat_r, stat_nxt;
	logic [4:0]  chan_r, chan_nxt;
	logic [1:0]  widx_r, widx_nxt;
	logic [31:0] desc_r, desc_nxt, next_r, next_nxt, dptr_r, dptr_nxt;
	logic [31:0] iq_r, iq_nxt, txd_r, txd_nxt, nd_r, nd_nxt;
	logic        vld_r, vld_nxt, take_r, take_nxt, txdn_r, txdn_nxt, rxdn_r, rxdn_nxt;

	// engine request side
	logic        eng_start, eng_wr, eng_dph, eng_done;
	logic [1:0]  eng_len;
	logic [31:0] eng_addr, eng_wdata, eng_rdata;

	// word count of the packet, rounded up
	logic [13:0] len_p3;
	logic [11:0] nw;
	assign len_p3 = {1'b0, len_r} + 14'h0003;
	assign nw     = len_p3[13:2]; // RULE_06

	// per-step derived addresses
	logic [31:0] data_addr, cfg_addr, vec_word;
	assign data_addr = dptr_r + {18'h0_0000, cnt_r, 2'b00};
	assign cfg_addr  = CFG_BASE_I + {24'h00_0000, chan_r, 3'h0};

	// ----------------------------------------------------------------
	// bus request per step
	// ----------------------------------------------------------------
	// one transaction at a time, one per word in the data steps; pend blocks a second issue
	always_comb begin
		eng_wr    = 1'b1;
		eng_len   = `HDDS_LEN_ONE;
		// vector word first, so the default data never reads a stale copy
		vec_word  = {`HDDS_VEC_TX, 3'h0, chan_r, 3'h0, len_r};
		eng_addr  = iq_r;
		eng_wdata = vec_word;
		case (st_r)
			hdds_pkg::S_TDESC, hdds_pkg::S_RDESC: begin
				eng_wr   = 1'b0;
				eng_len  = `HDDS_LEN_DESC; // RULE_05 RULE_09
				eng_addr = desc_r;
			end
			hdds_pkg::S_TDATA: begin
				eng_wr   = 1'b0;
				eng_addr = data_addr;
			end
			hdds_pkg::S_RDATA: begin
				eng_addr  = data_addr; // RULE_01
				eng_wdata = RX_DATA_I;
			end
			hdds_pkg::S_RSTAT: begin
				eng_addr  = desc_r; // RULE_02
				eng_wdata = {stat_r, 3'h0, len_r}; // RULE_10
			end
			hdds_pkg::S_TIV: eng_addr = iq_r; // RULE_08
			hdds_pkg::S_RIV: begin
				vec_word  = {`HDDS_VEC_RX, 3'h0, chan_r, 3'h0, len_r};
				eng_wdata = vec_word; // RULE_03 RULE_12
			end
			hdds_pkg::S_TCCB: begin
				eng_addr  = cfg_addr + `HDDS_CFG_TX; // RULE_07
				eng_wdata = next_r;
			end
			hdds_pkg::S_RCCB: begin
				eng_addr  = cfg_addr + `HDDS_CFG_RX; // RULE_11
				eng_wdata = next_r;
			end
			default: eng_wr = 1'b1;
		endcase
	end

	assign eng_start = (st_r != hdds_pkg::S_IDLE) && !pend_r;

	// ----------------------------------------------------------------
	// packet sequence
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		pend_nxt = pend_r;
		cnt_nxt  = cnt_r;
		len_nxt  = len_r;
		stat_nxt = stat_r;
		chan_nxt = chan_r;
		widx_nxt = widx_r;
		desc_nxt = desc_r;
		next_nxt = next_r;
		dptr_nxt = dptr_r;
		iq_nxt   = iq_r;
		txd_nxt  = txd_r;
		nd_nxt   = nd_r;
		vld_nxt  = 1'b0;
		take_nxt = 1'b0;
		txdn_nxt = 1'b0;
		rxdn_nxt = 1'b0;
		if (eng_start) begin
			pend_nxt = 1'b1;
		end else if (eng_done) begin
			pend_nxt = 1'b0;
		end
		// descriptor words arrive in order: control, link, data pointer
		if (eng_dph && (st_r == hdds_pkg::S_TDESC || st_r == hdds_pkg::S_RDESC)) begin
			widx_nxt = widx_r + 2'h1;
			case (widx_r)
				`HDDS_DW_CTRL: begin
					if (st_r == hdds_pkg::S_TDESC) begin
						len_nxt = eng_rdata[`HDDS_LEN_MSB:0];
					end
				end
				`HDDS_DW_NEXT: next_nxt = eng_rdata;
				`HDDS_DW_DPTR: dptr_nxt = eng_rdata;
				default: widx_nxt = 2'h0;
			endcase
		end
		case (st_r)
			hdds_pkg::S_IDLE: begin
				widx_nxt = `HDDS_DW_CTRL;
				cnt_nxt  = 12'h000;
				// transmit wins when both ask in one cycle
				if (TX_REQ_I) begin
					st_nxt   = hdds_pkg::S_TDESC;
					chan_nxt = TX_CHAN_I;
					desc_nxt = TX_DESC_I;
					iq_nxt   = TX_IQ_I;
				end else if (RX_REQ_I) begin
					st_nxt   = hdds_pkg::S_RDESC;
					chan_nxt = RX_CHAN_I;
					desc_nxt = RX_DESC_I;
					iq_nxt   = RX_IQ_I;
					len_nxt  = RX_LEN_I;
					stat_nxt = RX_STAT_I;
				end
			end
			hdds_pkg::S_TDESC: begin
				if (eng_done) begin
					st_nxt = (nw == 12'h000) ? hdds_pkg::S_TIV : hdds_pkg::S_TDATA; // RULE_13
				end
			end
			hdds_pkg::S_TDATA: begin
				if (eng_dph) begin
					txd_nxt = eng_rdata;
					vld_nxt = 1'b1;
				end
				if (eng_done) begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r + 12'h001 == nw) begin
						st_nxt = hdds_pkg::S_TIV; // RULE_13
					end
				end
			end
			hdds_pkg::S_TIV: begin
				if (eng_done) begin
					st_nxt = hdds_pkg::S_TCCB;
				end
			end
			hdds_pkg::S_TCCB: begin
				if (eng_done) begin
					st_nxt   = hdds_pkg::S_IDLE;
					nd_nxt   = next_r; // RULE_04
					txdn_nxt = 1'b1;
				end
			end
			hdds_pkg::S_RDESC: begin
				if (eng_done) begin
					st_nxt = (nw == 12'h000) ? hdds_pkg::S_RSTAT : hdds_pkg::S_RDATA;
				end
			end
			hdds_pkg::S_RDATA: begin
				if (eng_done) begin
					take_nxt = 1'b1;
					cnt_nxt  = cnt_r + 12'h001;
					if (cnt_r + 12'h001 == nw) begin
						st_nxt = hdds_pkg::S_RSTAT;
					end
				end
			end
			hdds_pkg::S_RSTAT: begin
				if (eng_done) begin
					st_nxt = hdds_pkg::S_RIV;
				end
			end
			hdds_pkg::S_RIV: begin
				if (eng_done) begin
					st_nxt = hdds_pkg::S_RCCB;
				end
			end
			hdds_pkg::S_RCCB: begin
				if (eng_done) begin
					st_nxt   = hdds_pkg::S_IDLE;
					nd_nxt   = next_r; // RULE_04
					rxdn_nxt = 1'b1;
				end
			end
			default: st_nxt = hdds_pkg::S_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			st_r   <= hdds_pkg::S_IDLE;
			pend_r <= 1'b0;
			cnt_r  <= 12'h000;
			len_r  <= 13'h0000;
			stat_r <= 16'h0000;
			chan_r <= 5'h00;
			widx_r <= 2'h0;
			desc_r <= `HDDS_ZERO32;
			next_r <= `HDDS_ZERO32;
			dptr_r <= `HDDS_ZERO32;
			iq_r   <= `HDDS_ZERO32;
			txd_r  <= `HDDS_ZERO32;
			nd_r   <= `HDDS_ZERO32;
			vld_r  <= 1'b0;
			take_r <= 1'b0;
			txdn_r <= 1'b0;
			rxdn_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			pend_r <= pend_nxt;
			cnt_r  <= cnt_nxt;
			len_r  <= len_nxt;
			stat_r <= stat_nxt;
			chan_r <= chan_nxt;
			widx_r <= widx_nxt;
			desc_r <= desc_nxt;
			next_r <= next_nxt;
			dptr_r <= dptr_nxt;
			iq_r   <= iq_nxt;
			txd_r  <= txd_nxt;
			nd_r   <= nd_nxt;
			vld_r  <= vld_nxt;
			take_r <= take_nxt;
			txdn_r <= txdn_nxt;
			rxdn_r <= rxdn_nxt;
		end
	end

	assign TX_DATA_O     = txd_r;
	assign TX_DATA_VLD_O = vld_r;
	assign RX_TAKE_O     = take_r;
	assign TX_DONE_O     = txdn_r;
	assign RX_DONE_O     = rxdn_r;
	assign NEXT_DESC_O   = nd_r;
	assign BUSY_O        = (st_r != hdds_pkg::S_IDLE);

	// ----------------------------------------------------------------
	// bus engine
	// ----------------------------------------------------------------
	hdds_pci_engine u_eng (
		.clk_i     (CLK_I),
		.rst_i     (RESET_I),
		.start_i   (eng_start),
		.wr_i      (eng_wr),
		.len_i     (eng_len),
		.addr_i    (eng_addr),
		.wdata_i   (eng_wdata),
		.dph_o     (eng_dph),
		.done_o    (eng_done),
		.rdata_o   (eng_rdata),
		.ad_i      (AD_I),
		.trdy_n_i  (TRDY_N_I),
		.ad_o      (AD_O),
		.ad_oe_n_o (AD_OE_N_O),
		.cbe_n_o   (CBE_N_O),
		.frame_n_o (FRAME_N_O),
		.irdy_n_o  (IRDY_N_O)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// data phases of the running transaction, for the checks only
	logic [1:0] ph_r;
	always_ff @(posedge CLK_I) begin
		if (RESET_I || eng_start) begin
			ph_r <= 2'h0;
		end else if (eng_dph) begin
			ph_r <= ph_r + 2'h1;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	property p_tdesc3;
		(eng_done && st_r == hdds_pkg::S_TDESC) |-> (ph_r == 2'h2 && !eng_wr);
	endproperty
	a_tdesc3: assert property (p_tdesc3) else $error("tx descriptor not 3 phases"); // RULE_05

	property p_rdesc3;
		(eng_done && st_r == hdds_pkg::S_RDESC) |-> (ph_r == 2'h2 && !eng_wr);
	endproperty
	a_rdesc3: assert property (p_rdesc3) else $error("rx descriptor not 3 phases"); // RULE_09

	property p_rdata1;
		(eng_done && st_r == hdds_pkg::S_RDATA) |-> (ph_r == 2'h0 && eng_wr);
	endproperty
	a_rdata1: assert property (p_rdata1) else $error("rx data write not single word"); // RULE_01

	property p_tcount;
		(st_r == hdds_pkg::S_TDATA && eng_done && st_nxt == hdds_pkg::S_TIV)
			|-> (cnt_r + 12'h001 == nw && ph_r == 2'h0);
	endproperty
	a_tcount: assert property (p_tcount) else $error("tx word count wrong"); // RULE_06

	property p_rstat;
		(eng_start && st_r == hdds_pkg::S_RSTAT) |-> (eng_addr == desc_r && eng_wr
			&& eng_len == 2'h1);
	endproperty
	a_rstat: assert property (p_rstat) else $error("status write-back wrong"); // RULE_10

	property p_riv;
		(eng_start && st_r == hdds_pkg::S_RIV) |-> (eng_addr == iq_r && eng_len == 2'h1);
	endproperty
	a_riv: assert property (p_riv) else $error("rx vector misplaced"); // RULE_12

	property p_tiv;
		(eng_done && st_r == hdds_pkg::S_TIV) |=> (st_r == hdds_pkg::S_TCCB && ph_r == 2'h1);
	endproperty
	a_tiv: assert property (p_tiv) else $error("tx vector not single phase"); // RULE_08

	property p_tdone;
		TX_DONE_O |-> ($past(st_r) == hdds_pkg::S_TCCB && NEXT_DESC_O == $past(next_r));
	endproperty
	a_tdone: assert property (p_tdone) else $error("tx link not followed"); // RULE_04

	property p_rccb;
		(eng_start && st_r == hdds_pkg::S_RCCB) |-> (eng_wdata == next_r
			&& eng_addr == cfg_addr + 32'h0000_0004);
	endproperty
	a_rccb: assert property (p_rccb) else $error("rx config block update wrong"); // RULE_11

	c_tx: cover property (st_r == hdds_pkg::S_TDATA && eng_done && st_nxt == hdds_pkg::S_TIV);
	c_rx: cover property (RX_DONE_O);
	c_wait: cover property (!IRDY_N_O && TRDY_N_I);

endmodule : hdds_sequencer
`default_nettype wire

// *** testbench/hdds_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// bus target with shared host memory
// ----------------------------------------------------------------
module hdds_mem_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// device side of the bus
	input  wire logic [31:0] dev_ad_i,
	input  wire logic [3:0]  cbe_n_i,
	input  wire logic        frame_n_i,
	input  wire logic        irdy_n_i,
	input  wire logic [3:0]  wait_i,
	// target answers
	output logic [31:0]      ad_o,
	output logic             trdy_n_o
);
	logic [31:0] mem [0:1023];
	logic        act_r;
	logic        drv_r;
	logic [3:0]  cmd_r;
	logic [31:0] adr_r;
	logic [31:0] st_r;
	logic [31:0] rd_r;
	int          nph_r;
	int          wc_r;
	// transaction log, read by the bench
	logic [3:0]  cmd_q[$];
	logic [31:0] adr_q[$];
	logic [31:0] dat_q[$];
	int          nph_q[$];

	// released AD shows the inverse of the last word, never a stale copy
	assign ad_o = drv_r ? rd_r : ~rd_r;

	// claim on frame, hold trdy off for wait_i + 1 cycles in every phase
	always @(posedge clk_i) begin
		if (rst_i) begin
			act_r    <= 1'b0;
			drv_r    <= 1'b0;
			trdy_n_o <= 1'b1;
		end else if (!act_r) begin
			if (!frame_n_i) begin
				act_r <= 1'b1;
				adr_r <= dev_ad_i;
				st_r  <= dev_ad_i;
				cmd_r <= cbe_n_i;
				nph_r <= 0;
				wc_r  <= 0;
			end
		end else if (!trdy_n_o) begin
			trdy_n_o <= 1'b1;
			drv_r    <= 1'b0;
			wc_r     <= 0;
			nph_r    <= nph_r + 1;
			adr_r    <= adr_r + 32'h4;
			if (cmd_r == 4'h7) begin
				mem[adr_r[11:2]] <= dev_ad_i;
			end
			// frame high at a completing phase marks the last one
			if (frame_n_i) begin
				act_r <= 1'b0;
				cmd_q.push_back(cmd_r);
				adr_q.push_back(st_r);
				nph_q.push_back(nph_r + 1);
				dat_q.push_back((cmd_r == 4'h7) ? dev_ad_i : rd_r);
			end
		end else if (!irdy_n_i) begin
			if (wc_r >= int'(wait_i)) begin
				trdy_n_o <= 1'b0;
				if (cmd_r == 4'h6) begin
					rd_r  <= mem[adr_r[11:2]];
					drv_r <= 1'b1;
				end
			end else begin
				wc_r <= wc_r + 1;
			end
		end
	end

endmodule : hdds_mem_model

`default_nettype wire

// *** testbench/hdds_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module hdds_sequencer_bench;
	logic        CLK_I, RESET_I, TX_REQ_I, RX_REQ_I, TRDY_N_I, RX_TAKE_O, TX_DATA_VLD_O;
	logic        BUSY_O, TX_DONE_O, RX_DONE_O, AD_OE_N_O, FRAME_N_O, IRDY_N_O;
	logic [4:0]  TX_CHAN_I, RX_CHAN_I;
	logic [12:0] RX_LEN_I;
	logic [15:0] RX_STAT_I;
	logic [31:0] TX_DESC_I, TX_IQ_I, RX_DESC_I, RX_IQ_I, RX_DATA_I, CFG_BASE_I;
	logic [31:0] AD_I, AD_O, TX_DATA_O, NEXT_DESC_O, tgt_ad, rx_idx;
	logic [3:0]  CBE_N_O, wt;
	logic [31:0] txq[$];
	int          n_mismatch, check_count;

	hdds_sequencer hdds_sequencer_i (.CLK_I(CLK_I), .RESET_I(RESET_I), .TX_REQ_I(TX_REQ_I),
		.TX_CHAN_I(TX_CHAN_I), .TX_DESC_I(TX_DESC_I), .TX_IQ_I(TX_IQ_I), .RX_REQ_I(RX_REQ_I),
		.RX_CHAN_I(RX_CHAN_I), .RX_DESC_I(RX_DESC_I), .RX_IQ_I(RX_IQ_I), .RX_LEN_I(RX_LEN_I),
		.RX_STAT_I(RX_STAT_I), .RX_DATA_I(RX_DATA_I), .RX_TAKE_O(RX_TAKE_O),
		.CFG_BASE_I(CFG_BASE_I), .TX_DATA_O(TX_DATA_O), .TX_DATA_VLD_O(TX_DATA_VLD_O),
		.BUSY_O(BUSY_O), .TX_DONE_O(TX_DONE_O), .RX_DONE_O(RX_DONE_O),
		.NEXT_DESC_O(NEXT_DESC_O), .AD_I(AD_I), .TRDY_N_I(TRDY_N_I), .AD_O(AD_O),
		.AD_OE_N_O(AD_OE_N_O), .CBE_N_O(CBE_N_O), .FRAME_N_O(FRAME_N_O), .IRDY_N_O(IRDY_N_O));

	hdds_mem_model hdds_mem_model_i (.clk_i(CLK_I), .rst_i(RESET_I), .dev_ad_i(AD_O),
		.cbe_n_i(CBE_N_O), .frame_n_i(FRAME_N_O), .irdy_n_i(IRDY_N_O), .wait_i(wt),
		.ad_o(tgt_ad), .trdy_n_o(TRDY_N_I));

	// shared AD wire: device wins while its enable is low
	assign AD_I      = AD_OE_N_O ? tgt_ad : AD_O;
	// next word shows while take stands: the design latches it at take's closing edge
	assign RX_DATA_I = 32'h5A5A_0000 + rx_idx + {31'h0, RX_TAKE_O};

	// collect transmit words, step receive words on each take
	always @(posedge CLK_I) begin
		if (TX_DATA_VLD_O === 1'b1) txq.push_back(TX_DATA_O);
		if (RX_TAKE_O === 1'b1) rx_idx <= rx_idx + 32'h1;
	end

	initial begin
		CLK_I = 1'b0;
		forever #10 CLK_I = ~CLK_I;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask : chk

	// one logged bus transaction: command, start address, phases, last data
	task chk_tr(input int i, input logic [3:0] c, input logic [31:0] a, input int n,
		input logic [31:0] d);
		chk(hdds_mem_model_i.cmd_q[i], c, "bus command");
		chk(hdds_mem_model_i.adr_q[i], a, "bus address");
		chk(32'(hdds_mem_model_i.nph_q[i]), 32'(n), "data phase count");
		chk(hdds_mem_model_i.dat_q[i], d, "bus data");
	endtask : chk_tr

	task results;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	task automatic wait_done(input bit rx);
		int k;
		for (k = 0; k < 3000; k++) begin
			@(posedge CLK_I);
			if ((rx ? RX_DONE_O : TX_DONE_O) === 1'b1) break;
		end
		#1;
		if (k == 3000) chk(32'h0, 32'h1, "no done pulse");
	endtask : wait_done

	task clear(input logic [3:0] w);
		wt = w;
		txq.delete();
		hdds_mem_model_i.cmd_q.delete();
		hdds_mem_model_i.adr_q.delete();
		hdds_mem_model_i.nph_q.delete();
		hdds_mem_model_i.dat_q.delete();
	endtask : clear

	// host-built descriptor lists and data sections
	task automatic prep(input logic [12:0] mt, input logic [12:0] mr);
		TX_DESC_I = 32'h0000_0100;
		TX_IQ_I = 32'h0000_0300;
		TX_CHAN_I = 5'h03;
		RX_DESC_I = 32'h0000_0400;
		RX_IQ_I = 32'h0000_0600;
		RX_CHAN_I = 5'h11;
		RX_LEN_I = mr;
		rx_idx = 32'h0;
		hdds_mem_model_i.mem[64] = {19'h0, mt};
		hdds_mem_model_i.mem[65] = 32'h0000_0180;
		hdds_mem_model_i.mem[66] = 32'h0000_0200;
		hdds_mem_model_i.mem[256] = 32'h0000_0000;
		hdds_mem_model_i.mem[257] = 32'h0000_0480;
		hdds_mem_model_i.mem[258] = 32'h0000_0500;
		for (int k = 0; k < 8; k++) hdds_mem_model_i.mem[128 + k] = 32'hC0DE_0000 + k;
	endtask : prep

	task automatic check_tx(input int o, input logic [12:0] m);
		int n;
		n = (int'(m) + 3) / 4;
		chk_tr(o, 4'h6, 32'h0000_0100, 3, 32'h0000_0200);
		chk(32'(txq.size()), 32'(n), "tx word count");
		for (int k = 0; k < n; k++) begin
			chk_tr(o + 1 + k, 4'h6, 32'h200 + 4 * k, 1, 32'hC0DE_0000 + k);
			chk(txq[k], 32'hC0DE_0000 + k, "tx data word");
		end
		chk_tr(o + n + 1, 4'h7, 32'h0000_0300, 1, {8'h01, 3'h0, 5'h03, 3'h0, m});
		chk_tr(o + n + 2, 4'h7, 32'h0000_0058, 1, 32'h0000_0180);
	endtask : check_tx

	task automatic check_rx(input int o, input logic [12:0] m);
		int n;
		n = (int'(m) + 3) / 4;
		chk_tr(o, 4'h6, 32'h0000_0400, 3, 32'h0000_0500);
		for (int k = 0; k < n; k++)
			chk_tr(o + 1 + k, 4'h7, 32'h500 + 4 * k, 1, 32'h5A5A_0000 + k);
		chk_tr(o + n + 1, 4'h7, 32'h0000_0400, 1, {16'hBEEF, 3'h0, m});
		chk_tr(o + n + 2, 4'h7, 32'h0000_0600, 1, {8'h02, 3'h0, 5'h11, 3'h0, m});
		chk_tr(o + n + 3, 4'h7, 32'h0000_00CC, 1, 32'h0000_0480);
		chk(hdds_mem_model_i.mem[256], {16'hBEEF, 3'h0, m}, "status word");
	endtask : check_rx

	task automatic s_tx(input logic [12:0] m, input logic [3:0] w);
		clear(w);
		prep(m, 13'h0);
		@(posedge CLK_I);
		#1 TX_REQ_I = 1'b1;
		@(posedge CLK_I);
		#1 TX_REQ_I = 1'b0;
		wait_done(1'b0);
		check_tx(0, m);
		chk(32'(hdds_mem_model_i.adr_q.size()), 32'((m + 3) / 4 + 3), "tx bus count");
		chk(NEXT_DESC_O, 32'h0000_0180, "next link");
	endtask : s_tx

	task automatic s_rx(input logic [12:0] m, input logic [3:0] w);
		clear(w);
		prep(13'h0, m);
		@(posedge CLK_I);
		#1 RX_REQ_I = 1'b1;
		@(posedge CLK_I);
		#1 RX_REQ_I = 1'b0;
		wait_done(1'b1);
		check_rx(0, m);
		chk(32'(hdds_mem_model_i.adr_q.size()), 32'((m + 3) / 4 + 4), "rx bus count");
		chk(NEXT_DESC_O, 32'h0000_0480, "next link");
	endtask : s_rx

	// both requests at once: receive waits, held, until transmit is done
	task s_both;
		clear(4'h1);
		prep(13'h5, 13'h2);
		@(posedge CLK_I);
		#1 TX_REQ_I = 1'b1;
		RX_REQ_I = 1'b1;
		@(posedge CLK_I);
		#1 TX_REQ_I = 1'b0;
		wait_done(1'b0);
		@(posedge CLK_I);
		#1 RX_REQ_I = 1'b0;
		chk(32'(BUSY_O), 32'h1, "held request taken");
		wait_done(1'b1);
		check_tx(0, 13'h5);
		check_rx(5, 13'h2);
	endtask : s_both

	initial begin
		// all scenarios together need a few thousand cycles at most
		#200_000;
		n_mismatch++;
		results();
	end

	initial begin
		n_mismatch = 0;
		check_count = 0;
		{TX_REQ_I, RX_REQ_I, RX_STAT_I, wt} = '0;
		RESET_I = 1'b1;
		CFG_BASE_I = 32'h0000_0040;
		RX_STAT_I = 16'hBEEF;
		clear(4'h0);
		prep(13'h0, 13'h0);
		repeat (6) @(posedge CLK_I);
		#1 RESET_I = 1'b0;
		chk({28'h0, BUSY_O, FRAME_N_O, IRDY_N_O, AD_OE_N_O}, 32'h7, "idle after reset");
		chk({28'h0, CBE_N_O}, 32'hF, "idle command");
		s_tx(13'h5, 4'h0);
		s_tx(13'h4, 4'h3);
		s_tx(13'h0, 4'h1);
		s_rx(13'h9, 4'h2);
		s_rx(13'h1, 4'h0);
		s_both();
		results();
	end

endmodule : hdds_sequencer_bench

`default_nettype wire
